// file: logic/acpc_pkg.sv
// shared constants for the converter control block
package acpc_pkg;
  localparam int unsigned ACPC_CLK_HZ = 20_000_000;
  localparam int unsigned ACPC_NUM_CH = 8;
  localparam int unsigned ACPC_CODE_W = 3;
  localparam int unsigned ACPC_RANGE_W = 24;
  localparam logic [23:0] ACPC_RANGE_RESET = 24'hFFFFFF;
  localparam logic [2:0] ACPC_CODE_OFF = 3'h0;
  localparam int unsigned ACPC_CONV_PER_CH_NS = 550;
  localparam int unsigned ACPC_CONV_PER_CH_CYC = (ACPC_CONV_PER_CH_NS * (ACPC_CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned ACPC_INIT_MS = 10;
  localparam int unsigned ACPC_INIT_CYC = ACPC_INIT_MS * (ACPC_CLK_HZ / 1000);
  localparam int unsigned ACPC_GRST_CYC_DEF = 64;
  localparam int unsigned ACPC_CNT_W = 24;
  localparam logic [2:0] ACPC_CHCNT_FULL = 3'h7;
endpackage : acpc_pkg

// file: logic/acpc_ctrl_if.sv
// interface between the sequencer and the conversion timer
`timescale 1ns/1ps
interface acpc_ctrl_if;
  logic start;
  logic abort;
  logic [3:0] n_ch;
  logic done;
  logic running;
  modport seq (output start, output abort, output n_ch, input done, input running);
  modport tmr (input start, input abort, input n_ch, output done, output running);
endinterface : acpc_ctrl_if

// file: logic/acpc_conv_timer.sv
// conversion timer: counts 550 ns per enabled channel
`timescale 1ns/1ps
module acpc_conv_timer
  import acpc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  acpc_ctrl_if.tmr ctl
);
  logic [15:0] cnt_q;
  logic run_q;
  logic done_q;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_q <= 16'h0000;
      run_q <= 1'b0;
      done_q <= 1'b0;
    end
    else if (ctl.abort)
    begin
      cnt_q <= 16'h0000;
      run_q <= 1'b0;
      done_q <= 1'b0;
    end
    else if (ctl.start && !run_q)
    begin
      // at least one cycle even with every channel off
      // busy trails the count by one cycle, so load one less to stay within 11N cycles
      cnt_q <= (ctl.n_ch == 4'h0) ? 16'h0001 : 16'(ctl.n_ch * ACPC_CONV_PER_CH_CYC - 1);
      run_q <= 1'b1;
      done_q <= 1'b0;
    end
    else if (run_q)
    begin
      cnt_q <= cnt_q - 16'h0001;
      done_q <= (cnt_q == 16'h0001);
      run_q <= (cnt_q != 16'h0001);
    end
    else
      done_q <= 1'b0;
  end

  assign ctl.done = done_q;
  assign ctl.running = run_q;
endmodule : acpc_conv_timer

// file: logic/acpc_top.sv
// converter control: start, busy, nap, power-down and global reset
`timescale 1ns/1ps
module acpc_top
  import acpc_pkg::*;
#(
  parameter int unsigned INIT_CYC = ACPC_INIT_CYC,
  parameter int unsigned GRST_CYC = ACPC_GRST_CYC_DEF
)
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic convert_start,
  input wire logic power_down_request,
  input wire logic [23:0] range_cfg_in,
  input wire logic range_cfg_we,
  output logic busy,
  output logic sample_hold,
  output logic nap_active,
  output logic powered_down,
  output logic global_reset,
  output logic window_open,
  output logic clear_output_regs,
  output logic [23:0] range_cfg
);
  initial
  begin
    if (INIT_CYC < 1 || INIT_CYC >= (1 << ACPC_CNT_W) || GRST_CYC < 1
        || GRST_CYC >= (1 << ACPC_CNT_W))
      $error("acpc_top: count parameters out of range");
  end

  typedef enum logic [2:0] {
    ACPC_ST_INIT = 3'b000,
    ACPC_ST_IDLE = 3'b001,
    ACPC_ST_CONV = 3'b010,
    ACPC_ST_NAP = 3'b011,
    ACPC_ST_PDN = 3'b100,
    ACPC_ST_GRST = 3'b101
  } acpc_state_t;

  function automatic logic [3:0] acpc_count_enabled(input logic [23:0] cfg);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < ACPC_NUM_CH; i++)
      if (cfg[i*ACPC_CODE_W +: ACPC_CODE_W] != ACPC_CODE_OFF)
        n = n + 4'h1;
    return n;
  endfunction : acpc_count_enabled

  acpc_state_t st_q;
  logic cs_m_q, cs_s_q, cs_d_q;
  logic pd_m_q, pd_s_q, pd_d_q;
  logic pd_armed_q;
  logic [ACPC_CNT_W-1:0] tmr_q;
  logic busy_q, sh_q, nap_q, pdn_q, grst_q, win_q, clr_q;
  logic [23:0] range_q;
  logic cs_rise, pd_rise, grst_trig;

  acpc_ctrl_if ctl ();

  acpc_conv_timer u_timer (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .ctl(ctl)
  );

  // two-stage synchronisers, then one delay stage for edge detection
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cs_m_q <= 1'b0;
      cs_s_q <= 1'b0;
      cs_d_q <= 1'b0;
      pd_m_q <= 1'b0;
      pd_s_q <= 1'b0;
      pd_d_q <= 1'b0;
    end
    else
    begin
      cs_m_q <= convert_start;
      cs_s_q <= cs_m_q;
      cs_d_q <= cs_s_q;
      pd_m_q <= power_down_request;
      pd_s_q <= pd_m_q;
      pd_d_q <= pd_s_q;
    end
  end

  assign cs_rise = cs_s_q && !cs_d_q;
  assign pd_rise = pd_s_q && !pd_d_q;
  assign grst_trig = pd_rise && pd_armed_q;

  // second power-down rise without a conversion in between
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      pd_armed_q <= 1'b0;
    else if (grst_trig || st_q == ACPC_ST_CONV)
      pd_armed_q <= 1'b0;
    else if (pd_rise)
      pd_armed_q <= 1'b1;
  end

  assign ctl.start = (st_q == ACPC_ST_IDLE || st_q == ACPC_ST_NAP) && cs_rise
    && !pd_s_q && !grst_trig;
  assign ctl.abort = grst_trig;
  assign ctl.n_ch = acpc_count_enabled(range_q);

  // main sequencer
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q <= ACPC_ST_INIT;
      tmr_q <= ACPC_CNT_W'(INIT_CYC);
    end
    else if (grst_trig)
    begin
      st_q <= ACPC_ST_GRST;
      tmr_q <= ACPC_CNT_W'(GRST_CYC);
    end
    else
    begin
      case (st_q)
        ACPC_ST_INIT:
        begin
          if (tmr_q > ACPC_CNT_W'(1))
            tmr_q <= tmr_q - ACPC_CNT_W'(1);
          else
            st_q <= pd_s_q ? ACPC_ST_PDN : ACPC_ST_IDLE;
        end
        ACPC_ST_IDLE:
        begin
          if (pd_s_q)
            st_q <= ACPC_ST_PDN;
          else if (ctl.start)
            st_q <= ACPC_ST_CONV;
        end
        ACPC_ST_CONV:
        begin
          if (ctl.done)
          begin
            if (pd_s_q)
              st_q <= ACPC_ST_PDN;
            else if (cs_s_q)
              st_q <= ACPC_ST_NAP;
            else
              st_q <= ACPC_ST_IDLE;
          end
        end
        ACPC_ST_NAP:
        begin
          if (pd_s_q)
            st_q <= ACPC_ST_PDN;
          else if (!cs_s_q)
            st_q <= ACPC_ST_IDLE;
        end
        ACPC_ST_PDN:
        begin
          if (!pd_s_q)
            st_q <= ACPC_ST_IDLE;
        end
        ACPC_ST_GRST:
        begin
          if (tmr_q > ACPC_CNT_W'(1))
            tmr_q <= tmr_q - ACPC_CNT_W'(1);
          else
          begin
            st_q <= ACPC_ST_INIT;
            tmr_q <= ACPC_CNT_W'(INIT_CYC);
          end
        end
        default:
          st_q <= ACPC_ST_INIT;
      endcase
    end
  end

  // busy and sample-hold follow the conversion
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      busy_q <= 1'b0;
      sh_q <= 1'b0;
    end
    else if (grst_trig)
    begin
      busy_q <= 1'b0;
      sh_q <= 1'b0;
    end
    else if (ctl.start)
    begin
      busy_q <= 1'b1;
      sh_q <= 1'b1;
    end
    else if (ctl.done)
    begin
      busy_q <= 1'b0;
      sh_q <= 1'b0;
    end
  end

  // status outputs
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      nap_q <= 1'b0;
      pdn_q <= 1'b0;
      grst_q <= 1'b0;
      win_q <= 1'b0;
      clr_q <= 1'b1;
    end
    else
    begin
      nap_q <= (st_q == ACPC_ST_NAP) && cs_s_q && !grst_trig;
      pdn_q <= pd_s_q && st_q != ACPC_ST_CONV;
      grst_q <= grst_trig || (st_q == ACPC_ST_GRST && tmr_q > ACPC_CNT_W'(1));
      clr_q <= grst_trig || (st_q == ACPC_ST_GRST);
      if (grst_trig || ctl.start || st_q == ACPC_ST_INIT || st_q == ACPC_ST_GRST)
        win_q <= (st_q == ACPC_ST_INIT) && tmr_q == ACPC_CNT_W'(1) && !grst_trig;
      else if (ctl.done)
        win_q <= 1'b1;
    end
  end

  // range codes, defaults on any reset
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      range_q <= ACPC_RANGE_RESET;
    else if (grst_trig || st_q == ACPC_ST_GRST)
      range_q <= ACPC_RANGE_RESET;
    else if (range_cfg_we && win_q)
      range_q <= range_cfg_in;
  end

  assign busy = busy_q;
  assign sample_hold = sh_q;
  assign nap_active = nap_q;
  assign powered_down = pdn_q;
  assign global_reset = grst_q;
  assign window_open = win_q;
  assign clear_output_regs = clr_q;
  assign range_cfg = range_q;

  sequence s_start;
    ctl.start;
  endsequence

  AST_BUSY_RISE: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_start |=> busy) else $error("busy did not rise on start");
  AST_BUSY_HOLD: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_start ##1 busy |-> busy until_with (ctl.done || $past(grst_trig)))
    else $error("busy fell early");
  AST_CONV_LEN: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_start |-> ##[1:90] !ctl.running) else $error("conversion too long");
  AST_PD_IGNORE: assert property (@(posedge sys_clk) disable iff (!nrst)
    pd_s_q |-> !ctl.start) else $error("start accepted in power-down");
  AST_PD_FINISH: assert property (@(posedge sys_clk) disable iff (!nrst)
    (st_q == ACPC_ST_CONV && pd_s_q && !grst_trig && !ctl.done) |=> st_q == ACPC_ST_CONV)
    else $error("power-down cut conversion");
  AST_GRST_HALT: assert property (@(posedge sys_clk) disable iff (!nrst)
    grst_trig |=> !busy && !ctl.running && global_reset) else $error("reset no halt");
  AST_GRST_RANGE: assert property (@(posedge sys_clk) disable iff (!nrst)
    grst_trig |=> range_cfg == ACPC_RANGE_RESET && clear_output_regs)
    else $error("range not restored");
  AST_NAP: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ctl.done && cs_s_q && !pd_s_q) |=> ##1 nap_active) else $error("no nap");
  AST_IDLE_LOW: assert property (@(posedge sys_clk) disable iff (!nrst)
    (st_q == ACPC_ST_PDN || st_q == ACPC_ST_INIT) |-> !busy)
    else $error("busy while idle");
endmodule : acpc_top

// file: bench/acpc_host_model.sv
// host model: drives the convert start and power down pins
`timescale 1ns/1ps
module acpc_host_model
#(
  parameter int unsigned INIT_CYC = 20
)
(
  sys_clk,
  convert_start,
  power_down_request
);
  input wire logic sys_clk;
  output logic convert_start;
  output logic power_down_request;
  initial
  begin
    convert_start = 1'b0;
    power_down_request = 1'b0;
  end
  // quiet acquisition gap of 12 cycles, then a 50 ns high pulse unless held for nap
  task automatic pulse(input bit hold);
    repeat (12) @(negedge sys_clk);
    convert_start = 1'b1;
    @(negedge sys_clk);
    if (!hold)
    begin
      convert_start = 1'b0;
    end
  endtask : pulse
  // leave nap: low for 9 cycles (450 ns), then rise
  task automatic wake;
    convert_start = 1'b0;
    repeat (9) @(negedge sys_clk);
    convert_start = 1'b1;
    @(negedge sys_clk);
  endtask : wake
  task automatic set_pd(input bit v);
    @(negedge sys_clk);
    power_down_request = v;
    if (!v)
    begin
      repeat (INIT_CYC + 8) @(negedge sys_clk);
    end
  endtask : set_pd
endmodule : acpc_host_model

// file: bench/testbench.sv
// self-checking testbench for the converter control block
`timescale 1ns/1ps
module testbench;
  import acpc_pkg::*;
  localparam int unsigned FULL = ACPC_CONV_PER_CH_CYC * 8;
  logic sys_clk, nrst, convert_start, power_down_request, range_cfg_we;
  logic [23:0] range_cfg_in, range_cfg;
  logic busy, sample_hold, nap_active, powered_down, global_reset, window_open, clear_output_regs;
  int err_total, checks, len, n;
  acpc_host_model #(.INIT_CYC(20)) u_host (.sys_clk(sys_clk), .convert_start(convert_start),
    .power_down_request(power_down_request));
  acpc_top #(.INIT_CYC(20), .GRST_CYC(4)) u_dut (.sys_clk(sys_clk), .nrst(nrst),
    .convert_start(convert_start), .power_down_request(power_down_request),
    .range_cfg_in(range_cfg_in), .range_cfg_we(range_cfg_we), .busy(busy),
    .sample_hold(sample_hold), .nap_active(nap_active), .powered_down(powered_down),
    .global_reset(global_reset), .window_open(window_open),
    .clear_output_regs(clear_output_regs), .range_cfg(range_cfg));
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict;
    $display("mismatches=%0d comparisons=%0d", err_total, checks);
    if (err_total == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict
  // length of the next busy pulse in cycles
  task automatic busy_len(output int l);
    n = 0;
    l = 0;
    while (busy !== 1'b1 && n < 20)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk(sample_hold, 1'b1);
    while (busy === 1'b1 && l < 200)
    begin
      @(negedge sys_clk);
      l++;
    end
    chk(window_open, 1'b1);
  endtask : busy_len
  task automatic t_init;
    chk(range_cfg, ACPC_RANGE_RESET);
    chk(clear_output_regs, 1'b1);
    repeat (30) @(negedge sys_clk);
    chk(window_open, 1'b1);
    chk(busy, 1'b0);
  endtask : t_init
  task automatic t_conv(input int exp);
    u_host.pulse(1'b0);
    busy_len(len);
    chk(len, exp);
  endtask : t_conv
  task automatic t_range;
    range_cfg_in = 24'h000009;
    range_cfg_we = 1'b1;
    @(negedge sys_clk);
    range_cfg_we = 1'b0;
    @(negedge sys_clk);
    chk(range_cfg, 24'h000009);
    t_conv(ACPC_CONV_PER_CH_CYC * 2);
  endtask : t_range
  task automatic t_nap;
    u_host.pulse(1'b1);
    busy_len(len);
    repeat (2) @(negedge sys_clk);
    chk(nap_active, 1'b1);
    u_host.wake();
    busy_len(len);
    chk(len, ACPC_CONV_PER_CH_CYC * 2);
    u_host.convert_start = 1'b0;
  endtask : t_nap
  task automatic t_pd;
    u_host.set_pd(1'b1);
    repeat (4) @(negedge sys_clk);
    chk(powered_down, 1'b1);
    u_host.pulse(1'b0);
    repeat (10) @(negedge sys_clk);
    chk(busy, 1'b0);
    u_host.set_pd(1'b0);
    u_host.pulse(1'b0);
    u_host.set_pd(1'b1);
    busy_len(len);
    chk(len, ACPC_CONV_PER_CH_CYC * 2);
    repeat (3) @(negedge sys_clk);
    chk(powered_down, 1'b1);
  endtask : t_pd
  task automatic t_grst;
    u_host.set_pd(1'b0);
    u_host.set_pd(1'b1);
    u_host.set_pd(1'b0);
    u_host.set_pd(1'b1);
    repeat (3) @(negedge sys_clk);
    chk(global_reset, 1'b1);
    chk(clear_output_regs, 1'b1);
    chk(range_cfg, ACPC_RANGE_RESET);
    repeat (6) @(negedge sys_clk);
    chk(global_reset, 1'b0);
    chk(powered_down, 1'b1);
    u_host.set_pd(1'b0);
    t_conv(FULL);
  endtask : t_grst
  initial
  begin
    #400000;
    err_total++;
    give_verdict();
  end
  initial
  begin
    err_total = 0;
    checks = 0;
    nrst = 1'b0;
    range_cfg_in = 24'h000000;
    range_cfg_we = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk(range_cfg, ACPC_RANGE_RESET);
    chk(clear_output_regs, 1'b1);
    chk(window_open, 1'b0);
    chk(busy, 1'b0);
    nrst = 1'b1;
    t_init();
    t_conv(FULL);
    t_range();
    t_nap();
    t_pd();
    t_grst();
    give_verdict();
  end
endmodule : testbench
